// ### hdl/cexr_defs.svh
/*
  constants of the exception entry and return unit: status word fields,
  mode codes, bank indices, vectors, link offsets, register offsets.
  assumes: included by bare name wherever these names are used.
*/
`ifndef CEXR_DEFS_SVH
`define CEXR_DEFS_SVH

// status word field positions
`define CEXR_BIT_N      31
`define CEXR_BIT_Z      30
`define CEXR_BIT_C      29
`define CEXR_BIT_V      28
`define CEXR_BIT_J      24
`define CEXR_BIT_I      7
`define CEXR_BIT_F      6
`define CEXR_BIT_T      5
`define CEXR_MODE_HI    4
`define CEXR_MODE_LO    0
`define CEXR_COND_HI    31
`define CEXR_COND_LO    28
`define CEXR_STATUS_RST 32'h0000_00D3

// mode field codes
`define CEXR_MODE_USR   5'h10
`define CEXR_MODE_FIQ   5'h11
`define CEXR_MODE_IRQ   5'h12
`define CEXR_MODE_SVC   5'h13
`define CEXR_MODE_ABT   5'h17
`define CEXR_MODE_UND   5'h1B
`define CEXR_MODE_SYS   5'h1F

// bank indices
`define CEXR_BK_USR     3'h0
`define CEXR_BK_FIQ     3'h1
`define CEXR_BK_IRQ     3'h2
`define CEXR_BK_SVC     3'h3
`define CEXR_BK_ABT     3'h4
`define CEXR_BK_UND     3'h5

// vector addresses
`define CEXR_VEC_RST    32'h0000_0000
`define CEXR_VEC_UND    32'h0000_0004
`define CEXR_VEC_SWI    32'h0000_0008
`define CEXR_VEC_PABT   32'h0000_000C
`define CEXR_VEC_DABT   32'h0000_0010
`define CEXR_VEC_IRQ    32'h0000_0018
`define CEXR_VEC_FIQ    32'h0000_001C

// link and return offsets
`define CEXR_OFF_0      32'h0000_0000
`define CEXR_OFF_2      32'h0000_0002
`define CEXR_OFF_4      32'h0000_0004
`define CEXR_OFF_8      32'h0000_0008

// breakpoint encodings, wide and compressed
`define CEXR_BRK_MASK   32'h0FF0_00F0
`define CEXR_BRK_VAL    32'h0120_0070
`define CEXR_SBRK_MASK  32'h0000_FF00
`define CEXR_SBRK_VAL   32'h0000_BE00

// register byte offsets
`define CEXR_A_STATUS   8'h00
`define CEXR_A_SAVED    8'h04
`define CEXR_A_LINK     8'h08
`define CEXR_A_STACK    8'h0C
`define CEXR_A_HI0      8'h10
`define CEXR_A_FETCH    8'h24
`define CEXR_A_EVENT    8'h28
`define CEXR_A_STEP     8'h04

`endif

// ### hdl/cexr_pkg.sv
/*
  types of the exception entry and return unit.
  assumes: referenced as cexr_pkg::name, never imported.
*/
package cexr_pkg;
  // exception kinds, in order of priority, reset highest
  typedef enum logic [2:0] {
    CEXR_EXC_NONE = 3'h0,
    CEXR_EXC_RST  = 3'h1,
    CEXR_EXC_DABT = 3'h2,
    CEXR_EXC_FIQ  = 3'h3,
    CEXR_EXC_IRQ  = 3'h4,
    CEXR_EXC_PABT = 3'h5,
    CEXR_EXC_UND  = 3'h6,
    CEXR_EXC_SWI  = 3'h7
  } cexr_exc_t;
endpackage

// ### hdl/cexr_exception_unit.sv
/*
  exception entry and return sequencer with banked link, saved status,
  stack pointer and fast-interrupt high registers, on an ahb-lite slave.
  assumes: one clock, execute-stage signals synchronous to it, single
  word transfers only, hsel already decoded for this block's region.
*/
// Behaviour
// - wide state: link gets pc plus 4/8
// - compressed state: link gets pc plus 2/4/8
// - entry copies status into mode's saved word
// - entry forces status mode field to exception
// - entry redirects fetch to exception vector
// - each exception mode keeps its own stack pointer, sys mode shares the usr one
// - entry sets irq mask flag, fast mask flag too on fiq and reset entry
// - return loads link minus offset, restores status
// - fast interrupt owns private r8 to r14
// - fetch abort raised only at execute
// - flushed aborted instruction raises nothing
// - breakpoint acts as fetch abort
// - breakpoint deferred to execute, dropped if flushed
// - wide instruction runs only if condition holds
`include "cexr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module cexr_exception_unit #(
  parameter int NUM_BANKS = 6,          // usr, fiq, irq, svc, abt, und
  parameter int HI_REGS   = 5           // private r8..r12 of fast mode
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ex_valid,
  input  wire logic [31:0] ex_instr,
  input  wire logic [31:0] ex_pc,
  input  wire logic        ex_fetch_abort,
  input  wire logic        ex_flush,
  input  wire logic        reset_req,
  input  wire logic        dabt_req,
  input  wire logic        fiq_req,
  input  wire logic        irq_req,
  input  wire logic        undef_req,
  input  wire logic        swi_req,
  input  wire logic        ret_req,
  output logic             fetch_redirect,
  output logic [31:0]      fetch_addr,
  output logic [31:0]      status_word,
  output logic [2:0]       exc_taken
);

  ////////////////////////////////////////////////////////////////////////
  // decoding functions
  // bank that holds a mode's private registers
  function automatic logic [2:0] bank_of(input logic [4:0] mode);
    case (mode)
      `CEXR_MODE_FIQ: bank_of = `CEXR_BK_FIQ;
      `CEXR_MODE_IRQ: bank_of = `CEXR_BK_IRQ;
      `CEXR_MODE_SVC: bank_of = `CEXR_BK_SVC;
      `CEXR_MODE_ABT: bank_of = `CEXR_BK_ABT;
      `CEXR_MODE_UND: bank_of = `CEXR_BK_UND;
      default:        bank_of = `CEXR_BK_USR;
    endcase
  endfunction
  // mode entered for each exception
  function automatic logic [4:0] exc_mode(input cexr_pkg::cexr_exc_t e);
    case (e)
      cexr_pkg::CEXR_EXC_FIQ:  exc_mode = `CEXR_MODE_FIQ;
      cexr_pkg::CEXR_EXC_IRQ:  exc_mode = `CEXR_MODE_IRQ;
      cexr_pkg::CEXR_EXC_DABT: exc_mode = `CEXR_MODE_ABT;
      cexr_pkg::CEXR_EXC_PABT: exc_mode = `CEXR_MODE_ABT;
      cexr_pkg::CEXR_EXC_UND:  exc_mode = `CEXR_MODE_UND;
      default:                 exc_mode = `CEXR_MODE_SVC;
    endcase
  endfunction
  // vector of each exception
  function automatic logic [31:0] exc_vec(input cexr_pkg::cexr_exc_t e);
    case (e)
      cexr_pkg::CEXR_EXC_UND:  exc_vec = `CEXR_VEC_UND;
      cexr_pkg::CEXR_EXC_SWI:  exc_vec = `CEXR_VEC_SWI;
      cexr_pkg::CEXR_EXC_PABT: exc_vec = `CEXR_VEC_PABT;
      cexr_pkg::CEXR_EXC_DABT: exc_vec = `CEXR_VEC_DABT;
      cexr_pkg::CEXR_EXC_IRQ:  exc_vec = `CEXR_VEC_IRQ;
      cexr_pkg::CEXR_EXC_FIQ:  exc_vec = `CEXR_VEC_FIQ;
      default:                 exc_vec = `CEXR_VEC_RST;
    endcase
  endfunction
  // offset added to the execute pc to form the saved return address
  function automatic logic [31:0] link_off(input cexr_pkg::cexr_exc_t e, input logic short_st);
    case (e)
      cexr_pkg::CEXR_EXC_DABT: link_off = `CEXR_OFF_8;
      cexr_pkg::CEXR_EXC_UND,
      cexr_pkg::CEXR_EXC_SWI:  link_off = short_st ? `CEXR_OFF_2 : `CEXR_OFF_4;
      cexr_pkg::CEXR_EXC_RST:  link_off = `CEXR_OFF_0;
      default:                 link_off = `CEXR_OFF_4;
    endcase
  endfunction
  // condition field check against the status flags
  function automatic logic cond_pass(input logic [3:0] c, input logic [31:0] s);
    logic n, z, cy, v;
    {n, z, cy, v} = s[`CEXR_BIT_N:`CEXR_BIT_V];
    case (c)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = cy;
      4'h3: cond_pass = !cy;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = cy && !z;
      4'h9: cond_pass = !cy || z;
      4'hA: cond_pass = n == v;
      4'hB: cond_pass = n != v;
      4'hC: cond_pass = !z && (n == v);
      4'hD: cond_pass = z || (n != v);
      4'hE: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] status_reg;                 // current status word
  logic [31:0] saved_reg  [NUM_BANKS];     // saved status per mode
  logic [31:0] link_reg   [NUM_BANKS];     // link register per mode
  logic [31:0] sp_reg     [NUM_BANKS];     // banked stack pointer per mode
  logic [31:0] hi_usr_reg [HI_REGS];       // r8..r12 of all other modes
  logic [31:0] hi_fiq_reg [HI_REGS];       // r8..r12 private to fast mode
  logic        abt_data_reg;               // abort bank entered by data abort
  logic        fetch_redirect_reg;         // one-cycle redirect strobe
  logic [31:0] fetch_addr_reg;             // redirect target
  cexr_pkg::cexr_exc_t exc_reg;            // last exception taken
  logic        dph_wr_reg;                 // write data phase pending
  logic        dph_rd_reg;                 // read data phase pending
  logic [7:0]  dph_addr_reg;               // data phase offset
  logic        hreadyout_reg;              // slave ready
  logic [31:0] hrdata_reg;                 // read data

  ////////////////////////////////////////////////////////////////////////
  // execute stage qualification and priority
  logic [2:0]  cur_bank;                   // bank of current mode
  logic        narrow;                     // compressed state
  logic        ex_exec;                    // instruction really executes
  logic        is_brk;                     // breakpoint in execute
  logic        pabt_hit;                   // fetch abort reaches execute
  cexr_pkg::cexr_exc_t win;                // winning exception this cycle
  logic        ret_fire;                   // return taken this cycle
  logic [31:0] ret_off;                    // return offset of current mode
  logic [31:0] ret_status;                 // saved word of current mode
  assign cur_bank = bank_of(status_reg[`CEXR_MODE_HI:`CEXR_MODE_LO]);
  assign narrow   = status_reg[`CEXR_BIT_T];
  // compressed instructions carry no condition field
  assign ex_exec  = ex_valid && !ex_flush &&
                    (narrow || cond_pass(ex_instr[`CEXR_COND_HI:`CEXR_COND_LO], status_reg));
  assign is_brk   = narrow ? ((ex_instr & `CEXR_SBRK_MASK) == `CEXR_SBRK_VAL)
                           : ((ex_instr & `CEXR_BRK_MASK) == `CEXR_BRK_VAL);
  // tagged abort raised only once in execute and not flushed
  assign pabt_hit = (ex_valid && !ex_flush && ex_fetch_abort) ||
                    (ex_exec && !ex_fetch_abort && is_brk);
  // fixed priority, reset highest
  always_comb begin
    if (reset_req)
      win = cexr_pkg::CEXR_EXC_RST;
    else if (dabt_req)
      win = cexr_pkg::CEXR_EXC_DABT;
    else if (fiq_req && !status_reg[`CEXR_BIT_F])
      win = cexr_pkg::CEXR_EXC_FIQ;
    else if (irq_req && !status_reg[`CEXR_BIT_I])
      win = cexr_pkg::CEXR_EXC_IRQ;
    else if (pabt_hit)
      win = cexr_pkg::CEXR_EXC_PABT;
    else if (ex_exec && undef_req)
      win = cexr_pkg::CEXR_EXC_UND;
    else if (ex_exec && swi_req)
      win = cexr_pkg::CEXR_EXC_SWI;
    else
      win = cexr_pkg::CEXR_EXC_NONE;
  end
  // return offset: interrupts and aborts step back, calls do not
  always_comb begin
    case (cur_bank)
      `CEXR_BK_FIQ, `CEXR_BK_IRQ: ret_off = `CEXR_OFF_4;
      `CEXR_BK_ABT:               ret_off = abt_data_reg ? `CEXR_OFF_8 : `CEXR_OFF_4;
      default:                    ret_off = `CEXR_OFF_0;
    endcase
  end
  assign ret_status = saved_reg[cur_bank];
  // user mode has nothing to return from
  assign ret_fire   = ret_req && (win == cexr_pkg::CEXR_EXC_NONE) && (cur_bank != `CEXR_BK_USR);

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes zero wait, reads one wait state
  logic ap_take;                           // address phase accepted
  logic wr_en;                             // write commits this cycle
  logic [31:0] rd_mux;                     // read data of dph offset
  assign ap_take     = hsel && htrans[1] && hready;
  assign wr_en       = dph_wr_reg && hready;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dph_wr_reg    <= 1'b0;
      dph_rd_reg    <= 1'b0;
      dph_addr_reg  <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= 32'h0000_0000;
    end else begin
      if (hready) begin
        dph_wr_reg   <= ap_take && hwrite;
        dph_rd_reg   <= ap_take && !hwrite;
        dph_addr_reg <= haddr[7:0];
      end
      // a read holds hready low one cycle, then presents data
      if (ap_take && !hwrite) begin
        hreadyout_reg <= 1'b0;
      end else if (!hreadyout_reg) begin
        hreadyout_reg <= 1'b1;
        hrdata_reg    <= rd_mux;
      end
    end
  end
  // read decode, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dph_addr_reg)
      `CEXR_A_STATUS: rd_mux = status_reg;
      `CEXR_A_SAVED:  rd_mux = saved_reg[cur_bank];
      `CEXR_A_LINK:   rd_mux = link_reg[cur_bank];
      `CEXR_A_STACK:  rd_mux = sp_reg[cur_bank];
      `CEXR_A_FETCH:  rd_mux = fetch_addr_reg;
      `CEXR_A_EVENT:  rd_mux = {29'h0000_0000, exc_reg};
      default: begin
        for (int i = 0; i < HI_REGS; i++) begin
          if (dph_addr_reg == `CEXR_A_HI0 + 8'(i) * `CEXR_A_STEP)
            rd_mux = (cur_bank == `CEXR_BK_FIQ) ? hi_fiq_reg[i] : hi_usr_reg[i];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // current status word
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= `CEXR_STATUS_RST;
    end else if (win != cexr_pkg::CEXR_EXC_NONE) begin
      status_reg <= status_reg;
      status_reg[`CEXR_MODE_HI:`CEXR_MODE_LO] <= exc_mode(win);
      status_reg[`CEXR_BIT_I] <= 1'b1;
      if (win == cexr_pkg::CEXR_EXC_FIQ || win == cexr_pkg::CEXR_EXC_RST)
        status_reg[`CEXR_BIT_F] <= 1'b1;
      status_reg[`CEXR_BIT_T] <= 1'b0;
      status_reg[`CEXR_BIT_J] <= 1'b0;
    end else if (ret_fire) begin
      status_reg <= ret_status;
    end else if (wr_en && dph_addr_reg == `CEXR_A_STATUS) begin
      status_reg <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-mode banks: entry wins over a bus write to the same bank
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        saved_reg[b] <= 32'h0000_0000;
        link_reg[b]  <= 32'h0000_0000;
        sp_reg[b]    <= 32'h0000_0000;
      end else if (win != cexr_pkg::CEXR_EXC_NONE && bank_of(exc_mode(win)) == 3'(b)) begin
        saved_reg[b] <= status_reg;
        link_reg[b]  <= ex_pc + link_off(win, narrow);
      end else if (wr_en && cur_bank == 3'(b)) begin
        if (dph_addr_reg == `CEXR_A_SAVED)
          saved_reg[b] <= hwdata;
        if (dph_addr_reg == `CEXR_A_LINK)
          link_reg[b] <= hwdata;
        if (dph_addr_reg == `CEXR_A_STACK)
          sp_reg[b] <= hwdata;
      end
    end
  end
  // fast mode sees its own r8..r12, every other mode the shared set
  for (genvar h = 0; h < HI_REGS; h++) begin : g_hi
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        hi_usr_reg[h] <= 32'h0000_0000;
        hi_fiq_reg[h] <= 32'h0000_0000;
      end else if (wr_en && dph_addr_reg == `CEXR_A_HI0 + 8'(h) * `CEXR_A_STEP) begin
        if (cur_bank == `CEXR_BK_FIQ)
          hi_fiq_reg[h] <= hwdata;
        else
          hi_usr_reg[h] <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fetch redirect and event record
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_redirect_reg <= 1'b0;
      fetch_addr_reg     <= `CEXR_VEC_RST;
      exc_reg            <= cexr_pkg::CEXR_EXC_NONE;
      abt_data_reg       <= 1'b0;
    end else begin
      fetch_redirect_reg <= (win != cexr_pkg::CEXR_EXC_NONE) || ret_fire;
      if (win != cexr_pkg::CEXR_EXC_NONE) begin
        fetch_addr_reg <= exc_vec(win);
        exc_reg        <= win;
      end else if (ret_fire) begin
        fetch_addr_reg <= link_reg[cur_bank] - ret_off;
      end
      if (win == cexr_pkg::CEXR_EXC_DABT || win == cexr_pkg::CEXR_EXC_PABT)
        abt_data_reg <= (win == cexr_pkg::CEXR_EXC_DABT);
    end
  end

  assign hreadyout      = hreadyout_reg;
  assign hrdata         = hrdata_reg;
  assign hresp          = 1'b0;
  assign fetch_redirect = fetch_redirect_reg;
  assign fetch_addr     = fetch_addr_reg;
  assign status_word    = status_reg;
  assign exc_taken      = exc_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_link_wide: assert property (win == cexr_pkg::CEXR_EXC_IRQ && !narrow |=>
    link_reg[`CEXR_BK_IRQ] == $past(ex_pc) + `CEXR_OFF_4) else $error("link after irq entry wrong");
  chk_link_short: assert property (win == cexr_pkg::CEXR_EXC_UND && narrow |=>
    link_reg[`CEXR_BK_UND] == $past(ex_pc) + `CEXR_OFF_2) else $error("link after compressed undefined wrong");
  chk_saved_copy: assert property (win == cexr_pkg::CEXR_EXC_IRQ |=>
    saved_reg[`CEXR_BK_IRQ] == $past(status_reg)) else $error("saved word not copied");
  chk_mode_force: assert property (win == cexr_pkg::CEXR_EXC_DABT |=>
    status_reg[`CEXR_MODE_HI:`CEXR_MODE_LO] == `CEXR_MODE_ABT) else $error("mode not forced");
  chk_vector_jump: assert property (win == cexr_pkg::CEXR_EXC_FIQ |=>
    fetch_redirect && fetch_addr == `CEXR_VEC_FIQ ##1 !fetch_redirect) else $error("vector redirect wrong");
  chk_mask_set: assert property (win != cexr_pkg::CEXR_EXC_NONE |=>
    status_reg[`CEXR_BIT_I]) else $error("irq mask not set");
  chk_return_path: assert property (ret_fire |=> status_reg == $past(ret_status) &&
    fetch_addr == $past(link_reg[cur_bank]) - $past(ret_off)) else $error("return restore wrong");
  chk_abort_drop: assert property (ex_flush |->
    win != cexr_pkg::CEXR_EXC_PABT) else $error("flushed abort raised");
  chk_brk_abort: assert property (ex_exec && is_brk && !ex_fetch_abort && !reset_req &&
    !dabt_req && !fiq_req && !irq_req |=> fetch_addr == `CEXR_VEC_PABT) else $error("breakpoint not abort");
  chk_cond_skip: assert property (ex_valid && !narrow && swi_req &&
    !cond_pass(ex_instr[`CEXR_COND_HI:`CEXR_COND_LO], status_reg) |-> win != cexr_pkg::CEXR_EXC_SWI)
    else $error("failed condition still executed");
  chk_reset_first: assert property (reset_req |=>
    exc_taken == cexr_pkg::CEXR_EXC_RST && fetch_addr == `CEXR_VEC_RST) else $error("reset lost priority");

  cov_irq_entry: cover property (win == cexr_pkg::CEXR_EXC_IRQ ##1 fetch_redirect);
  cov_pabt_entry: cover property (ex_fetch_abort && win == cexr_pkg::CEXR_EXC_PABT);
  cov_brk_entry: cover property (is_brk && win == cexr_pkg::CEXR_EXC_PABT);
  cov_return: cover property (win == cexr_pkg::CEXR_EXC_IRQ ##[1:20] ret_fire);
endmodule // cexr_exception_unit

`default_nettype wire

// ### verif/core_exception_entry_return_bench.sv
/*
  self-checking bench of the exception entry and return unit: drives the
  execute-stage requests and the ahb-lite register port, judges outputs.
  assumes: cexr_pkg and cexr_exception_unit compiled first, one 50 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module core_exception_entry_return_bench;
  logic        clock = 1'b0;            // core clock, 20 ns period
  logic        sys_rst = 1'b1;          // async reset, active high
  logic        hsel = 1'b0;             // bus select
  logic [31:0] haddr = 32'h0;           // bus address
  logic [1:0]  htrans = 2'h0;           // transfer type
  logic        hwrite = 1'b0;           // write strobe
  logic [31:0] hwdata = 32'h0;          // write data
  logic        hreadyout;               // slave ready, fed back as hready
  logic [31:0] hrdata;                  // read data
  logic        hresp;                   // response, always okay
  logic [6:0]  rq = 7'h0;               // reset dabt fiq irq undef swi ret
  logic [2:0]  vff = 3'h0;              // valid, fetch abort, flush
  logic [31:0] ex_pc = 32'h0;           // execute address
  logic [31:0] ex_instr = 32'h0;        // execute instruction word
  logic        fetch_redirect;          // redirect pulse
  logic [31:0] fetch_addr;              // redirect target
  logic [31:0] status_word;             // current status word
  logic [2:0]  exc_taken;               // last exception kind
  int          errors = 0;              // mismatches
  int          checks_done = 0;         // comparisons made

  // clock generator
  always #10 clock = ~clock;

  cexr_exception_unit dut (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ex_valid(vff[2]), .ex_instr(ex_instr), .ex_pc(ex_pc),
    .ex_fetch_abort(vff[1]), .ex_flush(vff[0]), .reset_req(rq[6]), .dabt_req(rq[5]),
    .fiq_req(rq[4]), .irq_req(rq[3]), .undef_req(rq[2]), .swi_req(rq[1]), .ret_req(rq[0]),
    .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr), .status_word(status_word),
    .exc_taken(exc_taken)
  );

  ////////////////////////////////////////////////////////////////////////
  // comparison, bus and request tasks

  // compare one value, report at once on mismatch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite word transfer; holds each phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // present requests for one cycle, then look just after the answer edge
  task automatic exc(input logic [6:0] r, input logic [2:0] v, input logic [31:0] pc, input logic [31:0] ins);
    @(posedge clock);
    rq <= r;
    vff <= v;
    ex_pc <= pc;
    ex_instr <= ins;
    @(posedge clock);
    rq <= 7'h0;
    vff <= 3'h0;
    #1;
  endtask

  // redirect pulse, vector and kind of an entry
  task automatic ent(input logic [31:0] vec, input logic [2:0] kind);
    chk({31'h0, fetch_redirect}, 32'h1);
    chk(fetch_addr, vec);
    chk({29'h0, exc_taken}, {29'h0, kind});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios

  task automatic t_reset();
    chk(status_word, 32'hD3);
    chk({29'h0, exc_taken}, 32'h0);
    chk({31'h0, fetch_redirect}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // interrupt entry from wide state, banked stack, then return
  task automatic t_irq();
    wr(8'h0C, 32'h1111_0000);
    wr(8'h00, 32'h13);
    exc(7'h08, 3'h0, 32'h100, 32'h0);
    ent(32'h18, 3'h4);
    chk(status_word, 32'h92);
    rdc(8'h08, 32'h104);
    rdc(8'h04, 32'h13);
    rdc(8'h0C, 32'h0);
    wr(8'h0C, 32'h2222_0000);
    exc(7'h01, 3'h0, 32'h0, 32'h0);
    chk(fetch_addr, 32'h100);
    chk(status_word, 32'h13);
    rdc(8'h0C, 32'h1111_0000);
  endtask

  // undefined instruction from compressed state
  task automatic t_short();
    wr(8'h00, 32'h33);
    exc(7'h04, 3'h4, 32'h200, 32'h0);
    ent(32'h04, 3'h6);
    chk(status_word, 32'h9B);
    rdc(8'h08, 32'h202);
    rdc(8'h04, 32'h33);
  endtask

  // fetch abort and breakpoint, flushed then executed
  task automatic t_pabt();
    wr(8'h00, 32'h13);
    exc(7'h00, 3'h7, 32'h300, 32'h0);
    chk({31'h0, fetch_redirect}, 32'h0);
    exc(7'h00, 3'h6, 32'h300, 32'h0);
    ent(32'h0C, 3'h5);
    rdc(8'h08, 32'h304);
    wr(8'h00, 32'h13);
    exc(7'h00, 3'h5, 32'h400, 32'hE120_0070);
    chk({31'h0, fetch_redirect}, 32'h0);
    exc(7'h00, 3'h4, 32'h400, 32'hE120_0070);
    ent(32'h0C, 3'h5);
    rdc(8'h08, 32'h404);
    exc(7'h01, 3'h0, 32'h0, 32'h0);
    chk(fetch_addr, 32'h400);
  endtask

  // condition field gates a software interrupt
  task automatic t_cond();
    wr(8'h00, 32'h13);
    exc(7'h02, 3'h4, 32'h500, 32'h0F00_0000);
    chk({31'h0, fetch_redirect}, 32'h0);
    wr(8'h00, 32'h4000_0013);
    exc(7'h02, 3'h4, 32'h500, 32'h0F00_0000);
    ent(32'h08, 3'h7);
    rdc(8'h08, 32'h504);
  endtask

  // simultaneous requests, data abort then reset winning
  task automatic t_prio();
    wr(8'h00, 32'h13);
    exc(7'h3E, 3'h4, 32'h600, 32'hE000_0000);
    ent(32'h10, 3'h2);
    rdc(8'h08, 32'h608);
    exc(7'h01, 3'h0, 32'h0, 32'h0);
    chk(fetch_addr, 32'h600);
    exc(7'h7F, 3'h4, 32'h700, 32'hE000_0000);
    ent(32'h00, 3'h1);
    chk(status_word, 32'hD3);
    rdc(8'h28, 32'h1);
    rdc(8'h24, 32'h0);
  endtask

  // fast interrupt over irq, private high registers
  task automatic t_fiq();
    wr(8'h10, 32'hAAAA_0000);
    wr(8'h00, 32'h13);
    exc(7'h18, 3'h0, 32'h800, 32'h0);
    ent(32'h1C, 3'h3);
    chk(status_word, 32'hD1);
    rdc(8'h10, 32'h0);
    wr(8'h10, 32'hBBBB_0000);
    rdc(8'h08, 32'h804);
    exc(7'h01, 3'h0, 32'h0, 32'h0);
    chk(fetch_addr, 32'h800);
    rdc(8'h10, 32'hAAAA_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_irq();
    t_short();
    t_pabt();
    t_cond();
    t_prio();
    t_fiq();
    stop_test();
  end

  // cut a hang short, far beyond the roughly 130 cycles needed
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule // core_exception_entry_return_bench

`default_nettype wire
